/* serial_pkg.sv */
// Shared constants and types for the asynchronous serial interface.
package serial_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_FRAME = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_BAUD = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned FR_NINTH_RX = 7;
  localparam int unsigned FR_NINTH_TX = 6;
  localparam int unsigned FR_WORD_LEN = 4;
  localparam int unsigned FR_WAKE_SEL = 3;
  localparam int unsigned C2_TX_EN = 3;
  localparam int unsigned C2_RX_EN = 2;
  localparam int unsigned C2_SLEEP = 1;
  localparam int unsigned ST_TX_EMPTY = 7;
  localparam int unsigned ST_TX_DONE = 6;
  localparam int unsigned ST_RX_FULL = 5;
  localparam int unsigned ST_IDLE = 4;
  localparam int unsigned ST_OVERRUN = 3;
  localparam int unsigned ST_NOISE = 2;
  localparam int unsigned ST_FRAMING = 1;
  localparam int unsigned BD_PRESC_HI = 5;
  localparam int unsigned BD_PRESC_LO = 4;
  localparam int unsigned BD_SEL_HI = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_TX_DONE = 1'b1;
  localparam logic [1:0] RST_PRESC = 2'h0;
  localparam logic [2:0] RST_SEL = 3'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam logic [3:0] PRESC_DIV_0 = 4'h1;
  localparam logic [3:0] PRESC_DIV_1 = 4'h3;
  localparam logic [3:0] PRESC_DIV_2 = 4'h4;
  localparam logic [3:0] PRESC_DIV_3 = 4'hd;
  localparam logic [3:0] SAMPLE_POS_A = 4'h8;
  localparam logic [3:0] SAMPLE_POS_B = 4'h9;
  localparam logic [3:0] SAMPLE_POS_C = 4'ha;
  localparam logic [3:0] RT_LAST = 4'hf;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [7:0] IDLE_RT_8 = 8'ha0;
  localparam logic [7:0] IDLE_RT_9 = 8'hb0;

  // ----------------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

endpackage : serial_pkg

/* async_serial_interface.sv */
// Asynchronous serial interface with APB register access.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Frames are start bit, eight or nine data bits, one stop bit.
// - Receiver and transmitter run independently on shared format and rate.
// - Receiver timing restarts at every detected start bit.
// - Each bit is sampled at sample positions 8, 9 and 10.
// - Bit value is the majority of its three samples.
// - Disagreeing samples on any bit set the noise flag.
// - Any high start verification sample sets noise, start may still pass.
// - Framing error without break resumes as if a stop bit arrived.
// - One transmitted bit lasts sixteen sample clock periods.
// - Data address reads receive holding, writes transmit holding storage.
// - Moving a received byte to the holding register sets receive-full.
// - Data is shifted in and out least significant bit first.
// - Enabled transmitter loads next byte after current one, on bit clock.
// - Frame control bit 7 holds ninth received, bit 6 ninth sent.
// - Frame control bit 4 selects eight or nine data bits.
// - Frame control bit 3 selects idle-line or address wake-up.
// - Wake-up applies only while the receiver sleep bit is set.
// - Idle-line wake lets the next byte fill and flag the receiver.
// - Address wake: most significant data bit one allows flags to set.
// - Idle flag sets after 10 or 11 consecutive one bits.
// - Receive-full clears by status read then data read; reset clears.
// - Transmit-empty clears by status read then data write; reset sets.
module async_serial_interface (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [serial_pkg::APB_AW-1:0] paddr_i,
  input wire logic [serial_pkg::APB_DW-1:0] pwdata_i,
  output logic [serial_pkg::APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic serial_rx_line_i,
  output logic serial_tx_line_o
);
  import serial_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] receive_holding_reg_q;
  logic [7:0] transmit_holding_reg_q;
  logic ninth_rx_bit_q;
  logic ninth_tx_bit_q;
  logic word_len_q;
  logic wake_sel_q;
  logic tx_en_q;
  logic rx_en_q;
  logic receiver_sleep_ctrl_q;
  logic transmit_empty_flag_q;
  logic tx_done_q;
  logic receive_full_flag_q;
  logic idle_flag_q;
  logic overrun_q;
  logic noise_flag_q;
  logic framing_error_flag_q;
  logic [1:0] baud_prescale_q;
  logic [2:0] baud_select_q;
  logic rx_arm_q;
  logic tx_arm_q;
  logic [APB_DW-1:0] prdata_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic setup;
  logic access;
  logic hit_data;
  logic hit_frame;
  logic hit_ctrl2;
  logic hit_status;
  logic hit_baud;
  logic hit_any;
  logic [7:0] rd_byte;
  logic wr_data;
  logic wr_frame;
  logic wr_ctrl2;
  logic wr_baud;
  logic rd_data;
  logic rd_status;

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;

  always_comb begin
    hit_data = 1'b0;
    hit_frame = 1'b0;
    hit_ctrl2 = 1'b0;
    hit_status = 1'b0;
    hit_baud = 1'b0;
    if (paddr_i == ADDR_DATA) begin
      hit_data = 1'b1;
    end else if (paddr_i == ADDR_FRAME) begin
      hit_frame = 1'b1;
    end else if (paddr_i == ADDR_CTRL2) begin
      hit_ctrl2 = 1'b1;
    end else if (paddr_i == ADDR_STATUS) begin
      hit_status = 1'b1;
    end else if (paddr_i == ADDR_BAUD) begin
      hit_baud = 1'b1;
    end
  end

  assign hit_any = hit_data | hit_frame | hit_ctrl2 | hit_status | hit_baud;
  assign wr_data = access & pwrite_i & hit_data;
  assign wr_frame = access & pwrite_i & hit_frame;
  assign wr_ctrl2 = access & pwrite_i & hit_ctrl2;
  assign wr_baud = access & pwrite_i & hit_baud;
  assign rd_data = access & ~pwrite_i & hit_data;
  assign rd_status = access & ~pwrite_i & hit_status;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_data) begin
      rd_byte = receive_holding_reg_q;
    end else if (hit_frame) begin
      rd_byte[FR_NINTH_RX] = ninth_rx_bit_q;
      rd_byte[FR_NINTH_TX] = ninth_tx_bit_q;
      rd_byte[FR_WORD_LEN] = word_len_q;
      rd_byte[FR_WAKE_SEL] = wake_sel_q;
    end else if (hit_ctrl2) begin
      rd_byte[C2_TX_EN] = tx_en_q;
      rd_byte[C2_RX_EN] = rx_en_q;
      rd_byte[C2_SLEEP] = receiver_sleep_ctrl_q;
    end else if (hit_status) begin
      rd_byte[ST_TX_EMPTY] = transmit_empty_flag_q;
      rd_byte[ST_TX_DONE] = tx_done_q;
      rd_byte[ST_RX_FULL] = receive_full_flag_q;
      rd_byte[ST_IDLE] = idle_flag_q;
      rd_byte[ST_OVERRUN] = overrun_q;
      rd_byte[ST_NOISE] = noise_flag_q;
      rd_byte[ST_FRAMING] = framing_error_flag_q;
    end else if (hit_baud) begin
      rd_byte[BD_PRESC_HI:BD_PRESC_LO] = baud_prescale_q;
      rd_byte[BD_SEL_HI:0] = baud_select_q;
    end
  end

  // Read data is captured in the setup cycle and stands through the access.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_q <= '0;
    end else if (setup & ~pwrite_i) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~hit_any;

  // The status value actually returned arms the clearing access that follows.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_arm_q <= 1'b0;
      tx_arm_q <= 1'b0;
    end else begin
      if (rd_status) begin
        rx_arm_q <= prdata_q[ST_RX_FULL] | prdata_q[ST_IDLE];
        tx_arm_q <= prdata_q[ST_TX_EMPTY] | prdata_q[ST_TX_DONE];
      end else begin
        if (rd_data) begin
          rx_arm_q <= 1'b0;
        end
        if (wr_data) begin
          tx_arm_q <= 1'b0;
        end
      end
    end
  end

  logic rx_clr;
  logic tx_clr;
  assign rx_clr = rd_data & rx_arm_q;
  assign tx_clr = wr_data & tx_arm_q;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Frame format bits keep their value across reset.
  always_ff @(posedge clk_i) begin
    if (wr_frame) begin
      ninth_tx_bit_q <= pwdata_i[FR_NINTH_TX];
      word_len_q <= pwdata_i[FR_WORD_LEN];
      wake_sel_q <= pwdata_i[FR_WAKE_SEL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_data) begin
      transmit_holding_reg_q <= pwdata_i[7:0];
    end
  end

  logic sleep_wake;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
      receiver_sleep_ctrl_q <= 1'b0;
    end else if (wr_ctrl2) begin
      tx_en_q <= pwdata_i[C2_TX_EN];
      rx_en_q <= pwdata_i[C2_RX_EN];
      receiver_sleep_ctrl_q <= pwdata_i[C2_SLEEP];
    end else if (sleep_wake) begin
      receiver_sleep_ctrl_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_prescale_q <= RST_PRESC;
      baud_select_q <= RST_SEL;
    end else if (wr_baud) begin
      baud_prescale_q <= pwdata_i[BD_PRESC_HI:BD_PRESC_LO];
      baud_select_q <= pwdata_i[BD_SEL_HI:0];
    end
  end

  // ----------------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------------
  logic [3:0] presc_cnt_q;
  logic [3:0] presc_div;
  logic presc_tick;
  logic [6:0] sel_cnt_q;
  logic [7:0] sel_mask_w;
  logic [6:0] sel_mask;
  logic rx_sample_clock;
  logic [3:0] tx_div_q;
  logic bit_tick;

  always_comb begin
    case (baud_prescale_q)
      2'h0: presc_div = PRESC_DIV_0;
      2'h1: presc_div = PRESC_DIV_1;
      2'h2: presc_div = PRESC_DIV_2;
      default: presc_div = PRESC_DIV_3;
    endcase
  end

  assign presc_tick = presc_cnt_q >= (presc_div - 4'h1);
  assign sel_mask_w = (8'h01 << baud_select_q) - 8'h01;
  assign sel_mask = sel_mask_w[6:0];
  assign rx_sample_clock = presc_tick & ((sel_cnt_q & sel_mask) == sel_mask);
  assign bit_tick = rx_sample_clock & (tx_div_q == RT_LAST);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc_cnt_q <= 4'h0;
      sel_cnt_q <= 7'h00;
    end else if (presc_tick) begin
      presc_cnt_q <= 4'h0;
      sel_cnt_q <= sel_cnt_q + 7'h01;
    end else begin
      presc_cnt_q <= presc_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_div_q <= 4'h0;
    end else if (rx_sample_clock) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  rx_state_t rx_state_q;
  logic [3:0] rt_pos_q;
  logic [3:0] rt_cur;
  logic [1:0] smp_q;
  logic [2:0] smp_all;
  logic vote;
  logic noisy;
  logic line_prev_q;
  logic [8:0] rx_shift_q;
  logic [3:0] rx_bits_q;
  logic [3:0] data_bits;
  logic noise_acc_q;
  logic zero_acc_q;
  logic frame_end;
  logic frame_fe;
  logic frame_noise;
  logic accept;
  logic [7:0] rx_byte;

  assign rt_cur = rt_pos_q + 4'h1;
  assign smp_all = {smp_q, serial_rx_line_i};
  assign vote = (smp_all[0] & smp_all[1]) | (smp_all[0] & smp_all[2])
              | (smp_all[1] & smp_all[2]);
  assign noisy = ~(&smp_all) & (|smp_all);
  assign data_bits = word_len_q ? DATA_BITS_9 : DATA_BITS_8;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state_q <= RX_IDLE;
      rt_pos_q <= 4'h0;
      smp_q <= 2'h0;
      line_prev_q <= 1'b1;
      rx_shift_q <= 9'h000;
      rx_bits_q <= 4'h0;
      noise_acc_q <= 1'b0;
      zero_acc_q <= 1'b0;
    end else if (!rx_en_q) begin
      rx_state_q <= RX_IDLE;
      line_prev_q <= 1'b1;
    end else if (rx_sample_clock) begin
      rt_pos_q <= rt_cur;
      if (rt_cur == SAMPLE_POS_A || rt_cur == SAMPLE_POS_B) begin
        smp_q <= {smp_q[0], serial_rx_line_i};
      end
      case (rx_state_q)
        RX_IDLE: begin
          line_prev_q <= serial_rx_line_i;
          if (line_prev_q & ~serial_rx_line_i) begin
            rx_state_q <= RX_START;
            rt_pos_q <= 4'h1;
          end
        end
        RX_START: begin
          if (rt_cur == SAMPLE_POS_C) begin
            if (vote) begin
              rx_state_q <= RX_IDLE;
              line_prev_q <= serial_rx_line_i;
            end else begin
              rx_state_q <= RX_DATA;
              noise_acc_q <= |smp_all;
              zero_acc_q <= 1'b1;
              rx_bits_q <= 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (rt_cur == SAMPLE_POS_C) begin
            rx_shift_q <= {vote, rx_shift_q[8:1]};
            noise_acc_q <= noise_acc_q | noisy;
            zero_acc_q <= zero_acc_q & ~vote;
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == data_bits - 4'h1) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        default: begin
          if (rt_cur == SAMPLE_POS_C) begin
            rx_state_q <= RX_IDLE;
            // A break must return to mark before a new start is seen;
            // a plain framing error behaves as if a stop bit arrived.
            line_prev_q <= ~(zero_acc_q & ~vote);
          end
        end
      endcase
    end
  end

  assign frame_end = rx_en_q & rx_sample_clock & (rx_state_q == RX_STOP)
                   & (rt_cur == SAMPLE_POS_C);
  assign frame_fe = ~vote;
  assign frame_noise = noise_acc_q | noisy;
  assign rx_byte = word_len_q ? rx_shift_q[7:0] : rx_shift_q[8:1];
  // The top data bit lands in bit 8 of the shifter in both word lengths.
  assign accept = ~receiver_sleep_ctrl_q
                | (wake_sel_q & rx_shift_q[8]);

  // Idle line detection counts sample clocks of continuous mark.
  logic [7:0] idle_cnt_q;
  logic [7:0] idle_thr;
  logic idle_hit;

  assign idle_thr = word_len_q ? IDLE_RT_9 : IDLE_RT_8;
  assign idle_hit = rx_en_q & rx_sample_clock & (rx_state_q == RX_IDLE)
                  & serial_rx_line_i
                  & (idle_cnt_q == idle_thr - 8'h01);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt_q <= 8'h00;
    end else if (!rx_en_q || rx_state_q != RX_IDLE || !serial_rx_line_i) begin
      idle_cnt_q <= 8'h00;
    end else if (rx_sample_clock && idle_cnt_q != idle_thr) begin
      idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  assign sleep_wake = receiver_sleep_ctrl_q
                    & ((idle_hit & ~wake_sel_q)
                       | (frame_end & wake_sel_q & rx_shift_q[8]));

  // ----------------------------------------------------------------------
  // Receive flags and holding register
  // ----------------------------------------------------------------------
  logic rx_load;
  logic rx_over;

  assign rx_load = frame_end & accept & ~(receive_full_flag_q & ~rx_clr);
  assign rx_over = frame_end & accept & receive_full_flag_q & ~rx_clr;

  always_ff @(posedge clk_i) begin
    if (rx_load) begin
      receive_holding_reg_q <= rx_byte;
      ninth_rx_bit_q <= rx_shift_q[8];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      receive_full_flag_q <= 1'b0;
      noise_flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_q <= 1'b0;
      idle_flag_q <= 1'b0;
    end else begin
      if (rx_load) begin
        receive_full_flag_q <= 1'b1;
        noise_flag_q <= frame_noise;
        framing_error_flag_q <= frame_fe;
      end else if (rx_clr) begin
        receive_full_flag_q <= 1'b0;
        noise_flag_q <= 1'b0;
        framing_error_flag_q <= 1'b0;
      end
      if (rx_over) begin
        overrun_q <= 1'b1;
      end else if (rx_clr) begin
        overrun_q <= 1'b0;
      end
      if (idle_hit & ~receiver_sleep_ctrl_q) begin
        idle_flag_q <= 1'b1;
      end else if (rx_clr) begin
        idle_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  tx_state_t tx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic tx_load;
  logic tx_finish;
  logic [10:0] tx_frame;

  assign tx_load = bit_tick & (tx_left_q <= 4'h1) & tx_en_q
                 & ~transmit_empty_flag_q;
  assign tx_finish = bit_tick & (tx_left_q == 4'h1) & ~tx_load;
  // Stop bit, optional ninth bit, data, start bit.
  assign tx_frame = word_len_q
                  ? {1'b1, ninth_tx_bit_q, transmit_holding_reg_q, 1'b0}
                  : {2'b11, transmit_holding_reg_q, 1'b0};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 11'h7ff;
      tx_left_q <= 4'h0;
    end else if (tx_load) begin
      tx_state_q <= TX_SHIFT;
      tx_shift_q <= tx_frame;
      tx_left_q <= word_len_q ? FRAME_BITS_9 : FRAME_BITS_8;
    end else if (bit_tick && tx_left_q != 4'h0) begin
      tx_shift_q <= {1'b1, tx_shift_q[10:1]};
      tx_left_q <= tx_left_q - 4'h1;
      if (tx_left_q == 4'h1) begin
        tx_state_q <= TX_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_tx_line_o <= 1'b1;
    end else begin
      serial_tx_line_o <= (tx_state_q == TX_SHIFT) ? tx_shift_q[0]
                                                   : 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      transmit_empty_flag_q <= RST_TX_EMPTY;
      tx_done_q <= RST_TX_DONE;
    end else begin
      if (tx_load) begin
        transmit_empty_flag_q <= 1'b1;
      end else if (tx_clr) begin
        transmit_empty_flag_q <= 1'b0;
      end
      if (tx_finish) begin
        tx_done_q <= 1'b1;
      end else if (tx_clr | tx_load) begin
        tx_done_q <= 1'b0;
      end
    end
  end

endmodule : async_serial_interface

/* async_serial_interface_chk.sv */
// Port level checker for the asynchronous serial interface.
`timescale 1ns/1ps
module async_serial_interface_chk
  import serial_pkg::*;
(
  input logic clk_i,
  input logic rstn_i,
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic [serial_pkg::APB_AW-1:0] paddr_i,
  input logic [serial_pkg::APB_DW-1:0] prdata_o,
  input logic pready_o,
  input logic pslverr_o,
  input logic serial_tx_line_o
);
  logic unm;
  assign unm = paddr_i[1:0] != 2'b00 || paddr_i > ADDR_BAUD;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_ready; pready_o; endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_err; pslverr_o == (psel_i && penable_i && unm); endproperty
  a_err: assert property (p_err) else $error("slave error");
  property p_rd0; psel_i && !penable_i && !pwrite_i && unm |=> !prdata_o;
  endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped data");
  property p_hi; prdata_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data");
  property p_hold; $changed(prdata_o) |-> $past(psel_i && !penable_i);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_idle; $rose(rstn_i) |-> serial_tx_line_o [*4]; endproperty
  a_idle: assert property (p_idle) else $error("line low");
  property p_bit; $changed(serial_tx_line_o) |=>
    $stable(serial_tx_line_o) [*8] ##1 $stable(serial_tx_line_o) [*7];
  endproperty
  a_bit: assert property (p_bit) else $error("short bit");
  property p_gap; $fell(serial_tx_line_o) |-> $past(serial_tx_line_o, 16);
  endproperty
  a_gap: assert property (p_gap) else $error("no stop");
endmodule : async_serial_interface_chk
bind async_serial_interface async_serial_interface_chk u_chk (.clk_i,
  .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .serial_tx_line_o);

/* serial_partner.sv */
// Remote serial device: sends frames on one line and decodes the other.
`timescale 1ns/1ps
module serial_partner #(
  parameter int BIT_CLKS = 16
) (
  input logic clk_i,
  input logic line_i,
  output logic line_o
);
  int nbits = 8;
  logic [8:0] got_q[$];
  logic [8:0] v;
  initial line_o = 1'b1;
  // A glitch inverts the middle sample of the start bit in 8-bit frames
  // and of data bit 0 in 9-bit frames; bad sends a low stop bit.
  task automatic send(input logic [8:0] d, input bit glitch, input bit bad);
    logic b;
    for (int i = 0; i <= nbits + 1; i++) begin
      for (int j = 0; j < BIT_CLKS; j++) begin
        @(posedge clk_i);
        b = i == 0 ? 1'b0 : i > nbits ? !bad : d[i-1];
        line_o <= (glitch && i == nbits - 8 && j == 8) ? !b : b;
      end
    end
    @(posedge clk_i);
    line_o <= 1'b1;
  endtask : send
  // A low stop bit stores an unknown word so that it never matches.
  always begin
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    v = '0;
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      v[i] = line_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    got_q.push_back(line_i ? v : 9'bx);
  end
endmodule : serial_partner

/* tb_async_serial_interface.sv */
// Self-checking bench for the asynchronous serial interface.
`timescale 1ns/1ps
module tb_async_serial_interface;
  import serial_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, pready_o, pslverr_o, rx_line, tx_line, err;
  logic [7:0] paddr_i = 8'h00, d;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic [8:0] sent[$];
  time t;
  int n_errors = 0, checks_done = 0, nine = 0;
  always #12.5 clk_i = ~clk_i;
  async_serial_interface dut (.clk_i, .rstn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .serial_rx_line_i(rx_line), .serial_tx_line_o(tx_line));
  serial_partner peer (.clk_i, .line_i(tx_line), .line_o(rx_line));
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'($urandom), b};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [4:0] rx_st(input logic nz, input logic fe);
    return {2'b11, 1'b0, nz, fe};
  endfunction : rx_st
  task automatic rx(input logic [8:0] w, input bit nz, input bit fe);
    peer.send(w, nz, fe);
    repeat (200) @(posedge clk_i);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r[5:1], rx_st(nz, fe));
    bus(1'b0, ADDR_FRAME, 8'h00);
    if (nine) chk(r[7], w[8]);
    bus(1'b0, ADDR_DATA, 8'h00);
    chk(r, {24'h0, w[7:0]});
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r[5:1], 5'h00);
  endtask : rx
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'ha2dc633d));
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r[7:1], 7'h60);
    bus(1'b0, ADDR_BAUD, 8'h00);
    chk(r[5:4], 2'h0);
    bus(1'b0, 8'h14, 8'h00);
    chk({err, r}, {1'b1, 32'h0});
    $display("END reset");
    for (int k = 0; k < 2; k++) begin
      nine = k;
      peer.nbits = 8 + k;
      bus(1'b1, ADDR_FRAME, k ? 8'h50 : 8'h00);
      bus(1'b1, ADDR_CTRL2, 8'h0c);
      for (int i = 0; i < 4; i++) begin
        d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
        sent.push_back({k[0], d});
        for (int j = 0; j < 400; j++) begin
          bus(1'b0, ADDR_STATUS, 8'h00);
          if (r[ST_TX_EMPTY] === 1'b1) break;
        end
        bus(1'b1, ADDR_DATA, d);
      end
      for (int i = 0; i < 4000 && peer.got_q.size() < 4; i++) @(posedge clk_i);
      foreach (sent[i]) chk(peer.got_q[i], sent[i]);
      peer.got_q.delete();
      sent.delete();
      rx({k[0], 8'($urandom)}, 1'b0, 1'b0);
      rx({1'b1, 8'($urandom)}, 1'b1, 1'b0);
      rx({1'b0, 8'($urandom) | 8'h01}, 1'b0, 1'b1);
      $display("END mode %0d", k);
    end
    nine = 0;
    peer.nbits = 8;
    bus(1'b1, ADDR_FRAME, 8'h08);
    bus(1'b1, ADDR_CTRL2, 8'h0e);
    peer.send(9'h012, 1'b0, 1'b0);
    repeat (40) @(posedge clk_i);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r[ST_RX_FULL], 1'b0);
    peer.send(9'h092, 1'b0, 1'b0);
    repeat (40) @(posedge clk_i);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r[ST_RX_FULL], 1'b1);
    bus(1'b0, ADDR_DATA, 8'h00);
    chk(r[7:0], 8'h92);
    repeat (200) @(posedge clk_i);
    bus(1'b1, ADDR_FRAME, 8'h00);
    bus(1'b1, ADDR_CTRL2, 8'h0e);
    peer.send(9'h034, 1'b0, 1'b0);
    repeat (40) @(posedge clk_i);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r[ST_RX_FULL], 1'b0);
    repeat (200) @(posedge clk_i);
    peer.send(9'h056, 1'b0, 1'b0);
    repeat (40) @(posedge clk_i);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(r[ST_RX_FULL], 1'b1);
    bus(1'b0, ADDR_DATA, 8'h00);
    chk(r[7:0], 8'h56);
    $display("END wake");
    bus(1'b1, ADDR_BAUD, 8'h11);
    bus(1'b0, ADDR_STATUS, 8'h00);
    bus(1'b1, ADDR_DATA, 8'h00);
    @(negedge tx_line);
    t = $time;
    @(posedge tx_line);
    chk(32'(($time - t) / 25), 32'(9 * 16 * 2 * PRESC_DIV_1));
    $display("END rate");
    finish_test();
  end
endmodule : tb_async_serial_interface
